// ==== verif/ldm_cmd_engine_sva.sv ====
// checker for the engine's character handshakes
// assumes one mclk domain with synchronous active-low nrst
`timescale 1ns/10ps
`include "ldm_consts.vh"
module ldm_chk (
    // clock and reset
    input wire mclk,
    input wire nrst,
    // requests
    input wire [7:0] rx_data,
    input wire rx_valid,
    input wire rx_ready,
    // answers
    input wire [7:0] tx_data,
    input wire tx_valid,
    input wire tx_ready,
    input wire busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ********
    // handshakes
    // ********
    chk_reset_idle: assert property (disable iff (1'b0) !nrst |=> rx_ready && !busy && !tx_valid)
        else $error("not idle after reset");
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer char moved");
    chk_idle_ready: assert property (!busy |-> rx_ready)
        else $error("idle but not ready");
    chk_frame_start: assert property (!busy && rx_valid && rx_data == `LDM_CHR_ENQ |=> busy)
        else $error("frame start missed");
    chk_drop_other: assert property (!busy && rx_valid && rx_data != `LDM_CHR_ENQ |=> !busy)
        else $error("stray char started frame");
    chk_no_stray_tx: assert property (!busy && !tx_valid |=> !tx_valid)
        else $error("answer without request");
    chk_wait_gap: assert property ($fell(rx_ready) && !tx_valid |=> !tx_valid)
        else $error("answer too early");
    chk_answer_due: assert property ($fell(rx_ready) |-> ##[1:600] (tx_valid || rx_ready))
        else $error("answer overdue");
    cover property ($rose(tx_valid) && tx_data == `LDM_CHR_ACK);
    cover property ($rose(tx_valid) && tx_data == `LDM_CHR_NAK);
    cover property ($rose(tx_valid) && tx_data == `LDM_CHR_STX);
endmodule
bind ldm_cmd_engine ldm_chk u_chk (.mclk(mclk), .nrst(nrst), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .busy(busy));

// ==== verif/ldm_host.sv ====
// host model: frames requests and gathers answer characters
// assumes one mclk domain; drives on falling edges
`timescale 1ns/10ps
module ldm_host (
    // clock
    input wire mclk,
    // requests
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire rx_ready,
    // answers
    input wire [7:0] tx_data,
    input wire tx_valid,
    output logic tx_ready
);
    byte unsigned rxq[$];
    int cyc = 0;
    int t_last = 0;
    int t_first = 0;
    bit slow = 0;
    byte unsigned sum_flip = 0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    // a slow host is ready for an answer char one cycle in four
    always @(negedge mclk) tx_ready <= !slow || cyc[1:0] == 2'h0;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (tx_valid && tx_ready) begin
            if (rxq.size() == 0) t_first = cyc;
            rxq.push_back(tx_data);
        end
    end
    function automatic string hx(input byte unsigned v);
        string d;
        d = "0123456789ABCDEF";
        return {d.substr(v / 16, v / 16), d.substr(v % 16, v % 16)};
    endfunction
    function automatic byte unsigned sum(input string s);
        byte unsigned a;
        a = 0;
        foreach (s[i]) a += s[i];
        return a;
    endfunction
    task automatic send(input string body, output bit ok);
        string f;
        int n;
        f = {"\005", body, hx(sum(body) ^ sum_flip)};
        ok = 1;
        foreach (f[i]) begin
            @(negedge mclk);
            rx_data = f[i];
            rx_valid = 1'b1;
            n = 0;
            // rx_ready is settled at the falling edge; the next rising edge takes
            while (!rx_ready && n < 500) begin
                @(negedge mclk);
                n++;
            end
            ok &= n < 500;
            @(posedge mclk);
            t_last = cyc;
        end
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the command engine
// assumes the engine, the host model and a 125 MHz clock
`timescale 1ns/10ps
module testbench;
    reg mclk;
    reg nrst;
    reg [7:0] station_id;
    wire [7:0] rx_data;
    wire [7:0] tx_data;
    wire rx_valid, rx_ready, tx_valid, tx_ready, busy;
    int fail_count = 0;
    int samples_checked = 0;
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    ldm_cmd_engine #(.WAIT_STEP_CYC(32'h00000004)) u_dut (.mclk(mclk), .nrst(nrst),
        .station_id(station_id), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy));
    ldm_host u_host (.mclk(mclk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    // ********
    // helpers
    // ********
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // send one request, then compare the answer or only its leading part
    task automatic frame(input string body, input string exp, input bit full);
        bit ok;
        int n;
        u_host.send(body, ok);
        n = 0;
        while ((busy !== 1'b0 || tx_valid !== 1'b0) && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        if (!ok || n == 2000) begin
            fail_count++;
            end_of_test();
        end
        if (full) check(16'(u_host.rxq.size()), 16'(exp.len()));
        foreach (exp[i]) check(u_host.rxq[i], exp[i]);
        u_host.rxq.delete();
    endtask
    function automatic string rd(input string d);
        string b;
        b = {"00FF", d, "\003"};
        return {"\002", b, u_host.hx(u_host.sum(b))};
    endfunction
    task automatic t_word_rw();
        frame("00FFWW0D0000017BC9", "\00600FF", 1);
        frame("00FFQW0D00001021234ABCD", "\00600FF", 1);
        frame("00FFQR0D0000003", rd("7BC91234ABCD"), 1);
    endtask
    task automatic t_limits();
        frame("00FFQR0D0000041", "\02500FF07", 1);
        frame("00FFQR0D0102302", "\02500FF07", 1);
        frame("00FFQR0M0000021", "\02500FF07", 1);
        frame("00FFQR0C0020021", "\02500FF07", 1);
        frame("00FFBT000", "\02500FF07", 1);
        frame("00FFWW0D000000", "\02500FF07", 1);
        frame("05FFQR0D0000001", "", 1);
        frame("00FFXX0", "\02500FF06", 1);
        frame("00FFQR0D000A001", "\02500FF09", 1);
        u_host.sum_flip = 8'h01;
        frame("00FFQR0D0000001", "\02500FF02", 1);
        u_host.sum_flip = 8'h00;
        frame("00FFQR0D0000001", rd("7BC9"), 1);
    endtask
    task automatic t_random();
        frame("00FFWT003M0016FFFFM00320000D00051234", "\00600FF", 1);
        frame("00FFBW0M003203101", "\00600FF", 1);
        frame("00FFBT003M00161M00180M00170", "\00600FF", 1);
        frame("00FFQR0M0001601", rd("FFF9"), 1);
        frame("00FFQR0M0003201", rd("0005"), 1);
        frame("00FFQR0D0000501", rd("1234"), 1);
        frame("00FFQT001C002000001", "\02500FF08", 1);
    endtask
    task automatic t_wait();
        int d;
        u_host.slow = 1;
        frame("00FFQRFD0000001", rd("7BC9"), 1);
        d = u_host.t_first - u_host.t_last;
        check(16'(d >= 60 && d <= 80), 16'h0001);
        u_host.slow = 0;
    endtask
    initial begin
        nrst = 1'b0;
        station_id = 8'h00;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        t_word_rw();
        t_limits();
        t_random();
        t_wait();
        end_of_test();
    end
endmodule

// ==== verilog/ldm_cmd_engine.v ====
// command interpreter for host link device memory reads and writes
// assumes framed characters arrive on the mclk domain with valid/ready
`timescale 1ns/10ps
`include "ldm_consts.vh"

module ldm_cmd_engine #(
    parameter [1:0] FAMILY = `LDM_FAM_NEWEST,
    parameter [31:0] WAIT_STEP_CYC = `LDM_WAIT_STEP_MS * `LDM_CLK_KHZ,
    parameter STG_DEPTH = 160,
    parameter MEM_WORDS = 4096,
    parameter BUF_AW = 1
) (
    // clock and reset
    input wire mclk,
    input wire nrst,
    // own station number
    input wire [7:0] station_id,
    // request characters
    input wire [7:0] rx_data,
    input wire rx_valid,
    output wire rx_ready,
    // response characters
    output wire [7:0] tx_data,
    output wire tx_valid,
    input wire tx_ready,
    // status
    output wire busy
);

// ****************************************************************
// states, commands, helpers
// ****************************************************************
localparam S_IDLE = 4'h0, S_STN = 4'h1, S_PCN = 4'h2, S_CMD = 4'h3, S_WAIT = 4'h4;
localparam S_DEV = 4'h5, S_DNUM = 4'h6, S_CNT = 4'h7, S_DATA = 4'h8, S_SUM = 4'h9;
localparam S_DLY = 4'ha, S_APPLY = 4'hb, S_TX = 4'hc;
localparam C_NONE = 3'h0, C_ERD = 3'h1, C_BBW = 3'h2, C_WBW = 3'h3;
localparam C_EWW = 3'h4, C_RBT = 3'h5, C_RWT = 3'h6, C_ERT = 3'h7;
localparam SMALL = (FAMILY == `LDM_FAM_SMALL);
localparam NEWEST = (FAMILY == `LDM_FAM_NEWEST);

function [4:0] hex_nib;
    input [7:0] c;
    begin
        if (c >= 8'h30 && c <= 8'h39)
            hex_nib = {1'b1, c[3:0]};
        else if (c >= 8'h41 && c <= 8'h46)
            hex_nib = {1'b1, c[3:0] + 4'h9};
        else
            hex_nib = 5'h00;
    end
endfunction

function [7:0] nib_hex;
    input [3:0] n;
    begin
        nib_hex = (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
    end
endfunction

function [2:0] cmd_code;
    input [15:0] a;
    begin
        case (a)
            `LDM_A_EXT_WORD_READ: cmd_code = NEWEST ? C_ERD : C_NONE;
            `LDM_A_EXT_WORD_WRITE: cmd_code = NEWEST ? C_EWW : C_NONE;
            `LDM_A_EXT_RANDOM_WORD_TEST: cmd_code = NEWEST ? C_ERT : C_NONE;
            `LDM_A_BIT_BLOCK_WRITE: cmd_code = C_BBW;
            `LDM_A_WORD_BLOCK_WRITE: cmd_code = C_WBW;
            `LDM_A_RANDOM_BIT_TEST: cmd_code = C_RBT;
            `LDM_A_RANDOM_WORD_TEST: cmd_code = C_RWT;
            default: cmd_code = C_NONE;
        endcase
    end
endfunction

function [7:0] cnt_limit;
    input [2:0] cmd;
    input bitdev;
    input c32;
    reg [7:0] l;
    begin
        case (cmd)
            C_ERD: l = bitdev ? `LDM_LIM_RD_BIT : `LDM_LIM_WORD;
            C_BBW: l = SMALL ? `LDM_LIM_BBW_SMALL : `LDM_LIM_BBW;
            C_WBW, C_EWW: l = bitdev ? `LDM_LIM_WR_BIT :
                (SMALL ? `LDM_LIM_WR_SMALL : `LDM_LIM_WORD);
            C_RBT: l = SMALL ? `LDM_LIM_RBT_SMALL : `LDM_LIM_RBT;
            C_RWT, C_ERT: l = SMALL ? `LDM_LIM_RWT_SMALL : `LDM_LIM_RWT;
            default: l = 8'h00;
        endcase
        if (c32 && l > `LDM_LIM_C32)
            l = `LDM_LIM_C32;
        cnt_limit = l;
    end
endfunction

// ****************************************************************
// state
// ****************************************************************
reg [3:0] state_reg;
reg [2:0] cmd_reg;
reg [7:0] stn_reg;
reg [7:0] pcn_reg;
reg [3:0] wait_reg;
reg [7:0] kind_reg;
reg [16:0] num_reg;
reg [15:0] acc_reg;
reg [2:0] dig_reg;
reg [8:0] left_reg;
reg [7:0] err_reg;
reg [7:0] sum_reg;
reg [11:0] waddr_reg;
reg [3:0] bpos_reg;
reg [31:0] dly_reg;
reg [7:0] ap_reg;
reg [7:0] stg_n_reg;
reg [1:0] ph_reg;
reg [2:0] idx_reg;
reg [7:0] tsum_reg;
reg [15:0] mem [0:MEM_WORDS-1];
reg [11:0] stg_addr [0:STG_DEPTH-1];
reg [15:0] stg_dat [0:STG_DEPTH-1];
reg [15:0] stg_msk [0:STG_DEPTH-1];
reg [7:0] buf_mem [0:(1<<BUF_AW)-1];
reg [BUF_AW-1:0] wp_reg;
reg [BUF_AW-1:0] rp_reg;
reg [BUF_AW:0] bcnt_reg;

wire take = rx_valid && rx_ready;
wire [4:0] hv = hex_nib(rx_data);
wire [15:0] hex_next = {acc_reg[11:0], hv[3:0]};
wire is_dec = (rx_data >= 8'h30) && (rx_data <= 8'h39);
wire is_bitch = (rx_data == 8'h30) || (rx_data == 8'h31);
wire wide = (cmd_reg == C_ERD) || (cmd_reg == C_EWW) || (cmd_reg == C_ERT);
wire bitg = (cmd_reg == C_BBW) || (cmd_reg == C_RBT);
wire rnd = (cmd_reg == C_RBT) || (cmd_reg == C_RWT) || (cmd_reg == C_ERT);
wire buf_in_ready = (bcnt_reg != (1 << BUF_AW));
wire push = (state_reg == S_TX) && buf_in_ready;
wire [15:0] rd_word = mem[waddr_reg];
wire [31:0] dly_lim = {28'h0000000, wait_reg} * WAIT_STEP_CYC;

assign rx_ready = (state_reg <= S_SUM);
assign busy = (state_reg != S_IDLE);

// ****************************************************************
// field length and device decode
// ****************************************************************
reg [2:0] fl_last;
reg dv_ok, dv_bit, dv_c32;
reg [16:0] dv_max;
reg [16:0] dv_off;
reg [11:0] dv_word;

always @* begin
    case (state_reg)
        S_WAIT, S_DEV: fl_last = 3'h0;
        S_DNUM: fl_last = wide ? 3'h4 : 3'h3;
        S_DATA: fl_last = bitg ? 3'h0 : 3'h3;
        default: fl_last = 3'h1;
    endcase
end

always @* begin
    dv_ok = 1'b1;
    dv_bit = 1'b0;
    dv_c32 = 1'b0;
    dv_max = 17'h00000;
    dv_off = num_reg;
    dv_word = 12'h000;
    case (kind_reg)
        `LDM_K_BIT: begin
            dv_bit = 1'b1;
            dv_max = `LDM_BIT_MAX;
            dv_off = {4'h0, num_reg[16:4]};
            dv_word = `LDM_BIT_BASE;
        end
        `LDM_K_DATA: begin
            dv_max = `LDM_DATA_MAX;
            dv_word = `LDM_DATA_BASE;
        end
        `LDM_K_FILE: begin
            dv_ok = wide;
            dv_max = `LDM_FILE_MAX;
            dv_word = `LDM_FILE_BASE;
        end
        `LDM_K_CNT: begin
            if (num_reg >= `LDM_WIDE_COUNTER_FIRST) begin
                dv_c32 = 1'b1;
                dv_max = `LDM_C32_MAX;
                dv_off = (num_reg - `LDM_WIDE_COUNTER_FIRST) << 1;
                dv_word = `LDM_C32_BASE;
            end else begin
                dv_max = `LDM_C16_MAX;
                dv_word = `LDM_C16_BASE;
            end
        end
        default: begin
            dv_ok = 1'b0;
        end
    endcase
    if (num_reg > dv_max)
        dv_ok = 1'b0;
    dv_word = dv_word + dv_off[11:0];
end

// ****************************************************************
// checks on count and items
// ****************************************************************
wire [7:0] cnt_now = hex_next[7:0];
wire unit16 = dv_bit && !bitg;
wire [16:0] span = unit16 ? {5'h00, cnt_now, 4'h0} : {9'h000, cnt_now};
wire [16:0] last_dev = num_reg + span - 17'h00001;
wire [7:0] blk_lim = cnt_limit(cmd_reg, unit16, dv_c32);
wire [7:0] rnd_lim = cnt_limit(cmd_reg, 1'b0, 1'b0);
wire blk_bad = !dv_ok || (cmd_reg == C_BBW && !dv_bit) || cnt_now == 8'h00 ||
    cnt_now > blk_lim || last_dev > dv_max;
wire rnd_cnt_bad = (cnt_now == 8'h00) || (cnt_now > rnd_lim);
wire [16:0] grp_last = num_reg + 17'h0000f;
wire item_bad = !dv_ok || ((cmd_reg == C_RBT) ? !dv_bit :
    (dv_c32 || (dv_bit && grp_last > dv_max)));

// ****************************************************************
// staging of writes, applied only after the whole frame checks out
// ****************************************************************
reg stage_en;
reg [11:0] stage_addr;
reg [15:0] stage_dat;
reg [15:0] stage_msk;

always @* begin
    stage_en = take && (state_reg == S_DATA) && (bitg || dig_reg == 3'h3) &&
        (stg_n_reg < STG_DEPTH);
    stage_addr = waddr_reg;
    stage_dat = hex_next;
    stage_msk = 16'hffff;
    if (bitg) begin
        stage_addr = rnd ? dv_word : waddr_reg;
        stage_msk = 16'h0001 << (rnd ? num_reg[3:0] : bpos_reg);
        stage_dat = rx_data[0] ? stage_msk : 16'h0000;
    end
end

always @(posedge mclk) begin
    if (stage_en) begin
        stg_addr[stg_n_reg] <= stage_addr;
        stg_dat[stg_n_reg] <= stage_dat;
        stg_msk[stg_n_reg] <= stage_msk;
    end
    if (state_reg == S_APPLY && ap_reg < stg_n_reg)
        mem[stg_addr[ap_reg]] <= (mem[stg_addr[ap_reg]] & ~stg_msk[ap_reg]) |
            (stg_dat[ap_reg] & stg_msk[ap_reg]);
end

// ****************************************************************
// response character
// ****************************************************************
reg [7:0] tx_char;
reg [3:0] rd_nib;

always @* begin
    case (idx_reg[1:0])
        2'h0: rd_nib = rd_word[15:12];
        2'h1: rd_nib = rd_word[11:8];
        2'h2: rd_nib = rd_word[7:4];
        default: rd_nib = rd_word[3:0];
    endcase
    tx_char = `LDM_CHR_ETX;
    if (ph_reg == 2'h0) begin
        case (idx_reg)
            3'h0: tx_char = (err_reg != `LDM_ERR_NONE) ? `LDM_CHR_NAK :
                ((cmd_reg == C_ERD) ? `LDM_CHR_STX : `LDM_CHR_ACK);
            3'h1: tx_char = nib_hex(stn_reg[7:4]);
            3'h2: tx_char = nib_hex(stn_reg[3:0]);
            3'h3: tx_char = nib_hex(pcn_reg[7:4]);
            default: tx_char = nib_hex(pcn_reg[3:0]);
        endcase
    end else if (ph_reg == 2'h1) begin
        if (err_reg != `LDM_ERR_NONE)
            tx_char = nib_hex(idx_reg[0] ? err_reg[3:0] : err_reg[7:4]);
        else
            tx_char = nib_hex(rd_nib);
    end else if (idx_reg != 3'h0) begin
        tx_char = nib_hex(idx_reg[0] ? tsum_reg[7:4] : tsum_reg[3:0]);
    end
end

// ****************************************************************
// two-entry response buffer
// ****************************************************************
wire pop = tx_valid && tx_ready;
assign tx_valid = (bcnt_reg != 0);
assign tx_data = buf_mem[rp_reg];

always @(posedge mclk) begin
    if (push)
        buf_mem[wp_reg] <= tx_char;
end

always @(posedge mclk) begin
    if (!nrst) begin
        wp_reg <= 0;
        rp_reg <= 0;
        bcnt_reg <= 0;
    end else begin
        if (push)
            wp_reg <= wp_reg + 1'b1;
        if (pop)
            rp_reg <= rp_reg + 1'b1;
        if (push && !pop)
            bcnt_reg <= bcnt_reg + 1'b1;
        else if (pop && !push)
            bcnt_reg <= bcnt_reg - 1'b1;
    end
end

// ****************************************************************
// request parser and sequencer
// ****************************************************************
wire fld_end = (dig_reg == fl_last);
wire [2:0] cmd_now = cmd_code({acc_reg[7:0], rx_data});
wire hex_state = (state_reg == S_STN) || (state_reg == S_PCN) || (state_reg == S_WAIT) ||
    (state_reg == S_CNT) || (state_reg == S_SUM) || (state_reg == S_DATA && !bitg);
wire char_bad = (hex_state && !hv[4]) || (state_reg == S_DNUM && !is_dec) ||
    (state_reg == S_DATA && bitg && !is_bitch);

always @(posedge mclk) begin
    if (!nrst) begin
        state_reg <= S_IDLE;
        cmd_reg <= C_NONE;
        stn_reg <= 8'h00;
        pcn_reg <= 8'h00;
        wait_reg <= 4'h0;
        kind_reg <= 8'h00;
        num_reg <= 17'h00000;
        acc_reg <= 16'h0000;
        dig_reg <= 3'h0;
        left_reg <= 9'h000;
        err_reg <= `LDM_ERR_NONE;
        sum_reg <= 8'h00;
        waddr_reg <= 12'h000;
        bpos_reg <= 4'h0;
        dly_reg <= 32'h00000000;
        ap_reg <= 8'h00;
        stg_n_reg <= 8'h00;
        ph_reg <= 2'h0;
        idx_reg <= 3'h0;
        tsum_reg <= 8'h00;
    end else if (state_reg == S_IDLE) begin
        if (take && rx_data == `LDM_CHR_ENQ) begin
            state_reg <= S_STN;
            cmd_reg <= C_NONE;
            wait_reg <= 4'h0;
            acc_reg <= 16'h0000;
            dig_reg <= 3'h0;
            err_reg <= `LDM_ERR_NONE;
            sum_reg <= 8'h00;
            stg_n_reg <= 8'h00;
        end
    end else if (take) begin
        if (state_reg != S_SUM)
            sum_reg <= sum_reg + rx_data;
        if (char_bad && err_reg == `LDM_ERR_NONE)
            err_reg <= `LDM_ERR_CHAR;
        if (stage_en)
            stg_n_reg <= stg_n_reg + 8'h01;
        acc_reg <= (state_reg == S_CMD) ? {acc_reg[7:0], rx_data} : hex_next;
        dig_reg <= fld_end ? 3'h0 : dig_reg + 3'h1;
        if (state_reg == S_DNUM)
            num_reg <= num_reg * 17'h0000a + {13'h0000, rx_data[3:0]};
        if (state_reg == S_DATA && bitg && !rnd) begin
            bpos_reg <= bpos_reg + 4'h1;
            if (bpos_reg == 4'hf)
                waddr_reg <= waddr_reg + 12'h001;
        end
        if (state_reg == S_DATA && rnd && !bitg && dig_reg == 3'h0) begin
            waddr_reg <= dv_word;
            if (item_bad && err_reg == `LDM_ERR_NONE)
                err_reg <= `LDM_ERR_DEV;
        end
        if (state_reg == S_DATA && rnd && bitg && item_bad && err_reg == `LDM_ERR_NONE)
            err_reg <= `LDM_ERR_DEV;
        if (fld_end) begin
            case (state_reg)
                S_STN: begin
                    stn_reg <= hex_next[7:0];
                    state_reg <= S_PCN;
                end
                S_PCN: begin
                    pcn_reg <= hex_next[7:0];
                    state_reg <= S_CMD;
                end
                S_CMD: begin
                    cmd_reg <= cmd_now;
                    if (cmd_now == C_NONE) begin
                        err_reg <= `LDM_ERR_CMD;
                        dly_reg <= 32'h00000000;
                        state_reg <= (stn_reg == station_id) ? S_DLY : S_IDLE;
                    end else begin
                        state_reg <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    wait_reg <= hv[3:0];
                    state_reg <= rnd ? S_CNT : S_DEV;
                end
                S_DEV: begin
                    kind_reg <= rx_data;
                    num_reg <= 17'h00000;
                    state_reg <= S_DNUM;
                end
                S_DNUM: begin
                    state_reg <= rnd ? S_DATA : S_CNT;
                end
                S_CNT: begin
                    if (rnd) begin
                        left_reg <= {1'b0, cnt_now};
                        if (rnd_cnt_bad && err_reg == `LDM_ERR_NONE)
                            err_reg <= `LDM_ERR_CNT;
                        // a zero count carries no items, the sum field follows
                        state_reg <= (cnt_now == 8'h00) ? S_SUM : S_DEV;
                    end else begin
                        waddr_reg <= dv_word;
                        bpos_reg <= num_reg[3:0];
                        left_reg <= dv_c32 ? {cnt_now, 1'b0} : {1'b0, cnt_now};
                        if (blk_bad && err_reg == `LDM_ERR_NONE)
                            err_reg <= `LDM_ERR_CNT;
                        // a refused write still consumes its data characters
                        state_reg <= (cmd_reg == C_ERD || cnt_now == 8'h00) ? S_SUM : S_DATA;
                    end
                end
                S_DATA: begin
                    left_reg <= left_reg - 9'h001;
                    if (!rnd && !bitg)
                        waddr_reg <= waddr_reg + 12'h001;
                    if (left_reg <= 9'h001)
                        state_reg <= S_SUM;
                    else if (rnd)
                        state_reg <= S_DEV;
                end
                default: begin
                    if (hex_next[7:0] != sum_reg && err_reg == `LDM_ERR_NONE)
                        err_reg <= `LDM_ERR_SUM;
                    dly_reg <= 32'h00000000;
                    state_reg <= (stn_reg == station_id) ? S_DLY : S_IDLE;
                end
            endcase
        end
    end else if (state_reg == S_DLY) begin
        dly_reg <= dly_reg + 32'h00000001;
        if (dly_reg >= dly_lim) begin
            ph_reg <= 2'h0;
            idx_reg <= 3'h0;
            tsum_reg <= 8'h00;
            ap_reg <= 8'h00;
            if (err_reg != `LDM_ERR_NONE || cmd_reg == C_ERD || stg_n_reg == 8'h00)
                state_reg <= S_TX;
            else
                state_reg <= S_APPLY;
        end
    end else if (state_reg == S_APPLY) begin
        ap_reg <= ap_reg + 8'h01;
        if (ap_reg + 8'h01 >= stg_n_reg)
            state_reg <= S_TX;
    end else if (push) begin
        if (!(ph_reg == 2'h0 && idx_reg == 3'h0) && !(ph_reg == 2'h2 && idx_reg != 3'h0))
            tsum_reg <= tsum_reg + tx_char;
        idx_reg <= idx_reg + 3'h1;
        if (ph_reg == 2'h0 && idx_reg == 3'h4) begin
            idx_reg <= 3'h0;
            ph_reg <= 2'h1;
            if (err_reg == `LDM_ERR_NONE && cmd_reg != C_ERD)
                state_reg <= S_IDLE;
        end else if (ph_reg == 2'h1 && err_reg != `LDM_ERR_NONE) begin
            if (idx_reg == 3'h1)
                state_reg <= S_IDLE;
        end else if (ph_reg == 2'h1 && idx_reg == 3'h3) begin
            idx_reg <= 3'h0;
            waddr_reg <= waddr_reg + 12'h001;
            left_reg <= left_reg - 9'h001;
            if (left_reg <= 9'h001)
                ph_reg <= 2'h2;
        end else if (ph_reg == 2'h2 && idx_reg == 3'h2) begin
            state_reg <= S_IDLE;
        end
    end
end

endmodule

// ==== verilog/ldm_consts.vh ====
// constants for the link device memory command engine
// assumes a single mclk domain; included by bare name
`ifndef LDM_CONSTS_VH
`define LDM_CONSTS_VH

// ****************************************************************
// framing characters
// ****************************************************************
`define LDM_CHR_ENQ 8'h05
`define LDM_CHR_STX 8'h02
`define LDM_CHR_ETX 8'h03
`define LDM_CHR_ACK 8'h06
`define LDM_CHR_NAK 8'h15

// ****************************************************************
// command character pairs
// ****************************************************************
`define LDM_A_EXT_WORD_READ 16'h5152
`define LDM_A_BIT_BLOCK_WRITE 16'h4257
`define LDM_A_WORD_BLOCK_WRITE 16'h5757
`define LDM_A_EXT_WORD_WRITE 16'h5157
`define LDM_A_RANDOM_BIT_TEST 16'h4254
`define LDM_A_RANDOM_WORD_TEST 16'h5754
`define LDM_A_EXT_RANDOM_WORD_TEST 16'h5154

// ****************************************************************
// device kinds, number ranges and word map
// ****************************************************************
`define LDM_K_BIT 8'h4d
`define LDM_K_DATA 8'h44
`define LDM_K_FILE 8'h52
`define LDM_K_CNT 8'h43
`define LDM_BIT_MAX 17'h003ff
`define LDM_BIT_BASE 12'h000
`define LDM_DATA_MAX 17'h003ff
`define LDM_DATA_BASE 12'h040
`define LDM_C16_MAX 17'h000c7
`define LDM_C16_BASE 12'h440
`define LDM_WIDE_COUNTER_FIRST 17'h000c8
`define LDM_C32_MAX 17'h000ff
`define LDM_C32_BASE 12'h508
`define LDM_FILE_MAX 17'h007ff
`define LDM_FILE_BASE 12'h578

// ****************************************************************
// point count limits
// ****************************************************************
`define LDM_LIM_WORD 8'h40
`define LDM_LIM_RD_BIT 8'h20
`define LDM_LIM_C32 8'h20
`define LDM_LIM_BBW 8'ha0
`define LDM_LIM_BBW_SMALL 8'h2e
`define LDM_LIM_WR_BIT 8'h0a
`define LDM_LIM_WR_SMALL 8'h0b
`define LDM_LIM_RBT 8'h14
`define LDM_LIM_RBT_SMALL 8'h0a
`define LDM_LIM_RWT 8'h0a
`define LDM_LIM_RWT_SMALL 8'h06

// ****************************************************************
// families, error codes, timing
// ****************************************************************
`define LDM_FAM_SMALL 2'h0
`define LDM_FAM_NEWEST 2'h2
`define LDM_ERR_NONE 8'h00
`define LDM_ERR_SUM 8'h02
`define LDM_ERR_CMD 8'h06
`define LDM_ERR_CNT 8'h07
`define LDM_ERR_DEV 8'h08
`define LDM_ERR_CHAR 8'h09
`define LDM_WAIT_STEP_MS 32'h0000000a
`define LDM_CLK_KHZ 32'h0001e848

`endif
